// [hdl/remask_pkg.sv]
// package: register map, field layout and bus types for the receiver event mask block
package remask_pkg;

	// ----------------------------------------
	// register indices and byte addresses
	// ----------------------------------------
	localparam logic [11:0] IDX_MASK_AB = 12'h094;
	localparam logic [11:0] IDX_MASK_CD = 12'h095;
	localparam logic [11:0] IDX_EVT_STATUS = 12'h0a0;
	localparam logic [11:0] IDX_EVT_RAW = 12'h0a1;
	localparam logic [13:0] ADDR_MASK_AB = {IDX_MASK_AB, 2'b00};
	localparam logic [13:0] ADDR_MASK_CD = {IDX_MASK_CD, 2'b00};
	localparam logic [13:0] ADDR_EVT_STATUS = {IDX_EVT_STATUS, 2'b00};
	localparam logic [13:0] ADDR_EVT_RAW = {IDX_EVT_RAW, 2'b00};

	// ----------------------------------------
	// field layout within one configuration nibble
	// ----------------------------------------
	localparam int NUM_CFG = 4;
	localparam int NUM_EVT = 16;
	localparam int FLD_WAKE = 0;
	localparam int FLD_FRAME_SYNC = 1;
	localparam int FLD_MSG_ID = 2;
	localparam int FLD_MSG_END = 3;
	localparam int CFG_HI_SHIFT = 4;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [15:0] RST_STATUS = 16'h0000;
	localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

	// one event nibble per receive configuration
	typedef struct packed {
		logic msgEnd;
		logic msgId;
		logic frameSync;
		logic wake;
	} remask_evt_t;

	typedef struct packed {
		logic [13:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} remask_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} remask_apb_rsp_t;

endpackage

// [hdl/remask_top.sv]
// receiver event interrupt masking with apb register access
// ----------------------------------------
// What this block does
// - mask bit 0 enables, 1 suppresses interrupt
// - both mask registers reset to zero
// - 094 serves A/B, 095 serves C/D
// - wake-up masks at bits 0 and 4
// - frame sync masks at bits 1 and 5
// - message id masks at bits 2 and 6
// - end of message masks at bits 3 and 7
// ----------------------------------------
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps

module remask_top
	import remask_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// apb slave
	input wire remask_apb_req_t apbReq,
	output remask_apb_rsp_t apbRsp,
	// receiver events, one-cycle pulses per configuration
	input wire remask_evt_t evtCfgA,
	input wire remask_evt_t evtCfgB,
	input wire remask_evt_t evtCfgC,
	input wire remask_evt_t evtCfgD,
	// interrupt to host
	output logic irq
);

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [7:0] eventMaskCfgAb;
	logic [7:0] eventMaskCfgCd;
	logic [15:0] evtStatus;
	logic [31:0] rdata;

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire logic setupPhase = apbReq.psel && !apbReq.penable;
	wire logic accessPhase = apbReq.psel && apbReq.penable;
	wire logic wrAccess = accessPhase && apbReq.pwrite;
	wire logic rdSetup = setupPhase && !apbReq.pwrite;
	wire logic hitAb = apbReq.paddr == ADDR_MASK_AB;
	wire logic hitCd = apbReq.paddr == ADDR_MASK_CD;
	wire logic hitStatus = apbReq.paddr == ADDR_EVT_STATUS;
	wire logic hitRaw = apbReq.paddr == ADDR_EVT_RAW;
	wire logic hitAny = hitAb || hitCd || hitStatus || hitRaw;
	// lane 0 carries the whole mask byte; other lanes alone change nothing
	wire logic wrLow = apbReq.pstrb[0];
	wire logic wrAb = wrAccess && hitAb && wrLow;
	wire logic wrCd = wrAccess && hitCd && wrLow;
	// status clears on the completing read, which is the access phase
	wire logic rdStatusDone = accessPhase && !apbReq.pwrite && hitStatus;

	// ----------------------------------------
	// event vector: nibble per configuration, A lowest
	// ----------------------------------------
	wire logic [15:0] evtRaw = {evtCfgD, evtCfgC, evtCfgB, evtCfgA};
	// mask words concatenate to the same bit order as the event vector
	wire logic [15:0] maskAll = {eventMaskCfgCd, eventMaskCfgAb};

	// ----------------------------------------
	// mask values as they stand after this edge
	// ----------------------------------------
	// irq looks at the post-write mask so that masking a pending event
	// drops the line on the same edge as the register update
	wire logic [7:0] next_eventMaskCfgAb = wrAb ? apbReq.pwdata[7:0] : eventMaskCfgAb;
	wire logic [7:0] next_eventMaskCfgCd = wrCd ? apbReq.pwdata[7:0] : eventMaskCfgCd;
	wire logic [15:0] next_maskAll = {next_eventMaskCfgCd, next_eventMaskCfgAb};

	logic [15:0] next_evtStatus;
	logic [31:0] next_rdata;

	// ----------------------------------------
	// sticky status, set wins over the read clear
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_EVT; gi++) begin : gStatus
			// a masked event is still recorded so software can poll it
			assign next_evtStatus[gi] = evtRaw[gi] ? 1'b1 :
				(rdStatusDone ? 1'b0 : evtStatus[gi]);
		end
	endgenerate

	// ----------------------------------------
	// read data mux, latched in setup so prdata is a flop
	// ----------------------------------------
	always_comb begin
		next_rdata = rdata;
		if (rdSetup) begin
			if (hitAb) begin
				next_rdata = {24'h00_0000, eventMaskCfgAb};
			end else if (hitCd) begin
				next_rdata = {24'h00_0000, eventMaskCfgCd};
			end else if (hitStatus) begin
				next_rdata = {16'h0000, evtStatus};
			end else if (hitRaw) begin
				next_rdata = {16'h0000, evtRaw};
			end else begin
				next_rdata = RDATA_IDLE;
			end
		end
	end

	// ----------------------------------------
	// clocked state
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			eventMaskCfgAb <= RST_MASK;
			eventMaskCfgCd <= RST_MASK;
		end else begin
			if (wrAb) begin
				eventMaskCfgAb <= apbReq.pwdata[7:0];
			end
			if (wrCd) begin
				eventMaskCfgCd <= apbReq.pwdata[7:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			evtStatus <= RST_STATUS;
			rdata <= RDATA_IDLE;
			irq <= 1'b0;
		end else begin
			evtStatus <= next_evtStatus;
			rdata <= next_rdata;
			irq <= |(next_evtStatus & ~next_maskAll);
		end
	end

	// ----------------------------------------
	// apb response: zero wait, error on unmapped
	// ----------------------------------------
	// every register is a flop, so no access ever needs a wait state
	assign apbRsp.pready = 1'b1;
	assign apbRsp.pslverr = accessPhase && !hitAny;
	assign apbRsp.prdata = rdata;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence wrAbSeq;
		setupPhase && apbReq.pwrite && hitAb ##1 wrAb;
	endsequence

	sequence wrCdSeq;
		setupPhase && apbReq.pwrite && hitCd ##1 wrCd;
	endsequence

	mask_ab_write_a: assert property (wrAbSeq |=> eventMaskCfgAb == $past(apbReq.pwdata[7:0]))
		else $error("a/b mask write not stored");

	mask_cd_write_a: assert property (wrCdSeq |=> eventMaskCfgCd == $past(apbReq.pwdata[7:0]))
		else $error("c/d mask write not stored");

	mask_reset_zero_a: assert property (@(posedge clk) disable iff (1'b0)
		!rst_n |=> eventMaskCfgAb == 8'h00 && eventMaskCfgCd == 8'h00)
		else $error("mask registers not zero after reset");

	irq_unmasked_a: assert property ((|(evtRaw & ~next_maskAll)) |=> irq)
		else $error("unmasked event did not raise interrupt");

	irq_masked_a: assert property (irq |-> |(evtStatus & ~maskAll))
		else $error("interrupt raised without unmasked status");

	wake_b_mask_a: assert property ((evtRaw == 16'h0010 && eventMaskCfgAb[4]
		&& evtStatus == 16'h0000 && !wrAb) |=> !irq)
		else $error("b wake-up not suppressed by bit 4");

	fsync_c_mask_a: assert property ((evtCfgC.frameSync && !next_eventMaskCfgCd[1]) |=> irq)
		else $error("c frame sync not enabled by bit 1 clear");

	msgid_b_mask_a: assert property ((evtRaw == 16'h0040 && eventMaskCfgAb[6]
		&& evtStatus == 16'h0000 && !wrAb) |=> !irq)
		else $error("b message id not suppressed by bit 6");

	msgend_d_mask_a: assert property ((evtCfgD.msgEnd && !next_eventMaskCfgCd[7]) |=> irq)
		else $error("d end of message not enabled by bit 7 clear");

	status_sticky_a: assert property (evtRaw[0] |=> evtStatus[0]
		##1 (evtStatus[0] || $past(rdStatusDone)))
		else $error("status bit lost");

	msgend_b_mask_a: assert property ((evtRaw == 16'h0080 && eventMaskCfgAb[7]
		&& evtStatus == 16'h0000 && !wrAb) |=> !irq)
		else $error("b end of message not suppressed by bit 7");

	sequence wakeASeq;
		!irq && evtStatus == 16'h0000 ##0 evtCfgA.wake && !next_eventMaskCfgAb[0];
	endsequence

	wake_a_enable_a: assert property (wakeASeq |=> irq)
		else $error("a wake-up not enabled by bit 0 clear");

	// ----------------------------------------
	// reset state of everything software can see
	// ----------------------------------------
	out_reset_a: assert property (@(posedge clk) disable iff (1'b0)
		!rst_n |=> apbRsp.prdata == 32'h0000_0000 && !irq && evtStatus == 16'h0000)
		else $error("outputs not idle after reset");

	// ----------------------------------------
	// bus response
	// ----------------------------------------
	// pready is tied high, so every access phase is also the completing edge
	pready_high_a: assert property (apbRsp.pready)
		else $error("pready not high");

	slverr_unmapped_a: assert property ((accessPhase && !hitAny) |-> apbRsp.pslverr)
		else $error("unmapped access not flagged");

	slverr_mapped_a: assert property ((!accessPhase || hitAny) |-> !apbRsp.pslverr)
		else $error("error flagged on a mapped access");

	sequence rdAbSeq;
		rdSetup && hitAb;
	endsequence

	sequence rdCdSeq;
		rdSetup && hitCd;
	endsequence

	rd_ab_value_a: assert property (rdAbSeq |=>
		apbRsp.prdata == {24'h00_0000, $past(eventMaskCfgAb)})
		else $error("a/b mask read back wrong");

	rd_cd_value_a: assert property (rdCdSeq |=>
		apbRsp.prdata == {24'h00_0000, $past(eventMaskCfgCd)})
		else $error("c/d mask read back wrong");

	rd_status_value_a: assert property ((rdSetup && hitStatus) |=>
		apbRsp.prdata == {16'h0000, $past(evtStatus)})
		else $error("status read back wrong");

	rd_raw_value_a: assert property ((rdSetup && hitRaw) |=>
		apbRsp.prdata == {16'h0000, $past(evtRaw)})
		else $error("raw event view read back wrong");

	rd_unmapped_a: assert property ((rdSetup && !hitAny) |=> apbRsp.prdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	rd_mask_upper_a: assert property ((rdSetup && (hitAb || hitCd)) |=>
		apbRsp.prdata[31:8] == 24'h00_0000)
		else $error("mask read upper bits not zero");

	rd_evt_upper_a: assert property ((rdSetup && (hitStatus || hitRaw)) |=>
		apbRsp.prdata[31:16] == 16'h0000)
		else $error("event read upper bits not zero");

	// prdata only moves on a read setup, so a slow master still sees its word
	prdata_hold_a: assert property (!rdSetup |=> $stable(apbRsp.prdata))
		else $error("read data moved outside a read setup");

	// ----------------------------------------
	// sticky status
	// ----------------------------------------
	sequence rdStatusSeq;
		setupPhase && !apbReq.pwrite && hitStatus ##1 rdStatusDone;
	endsequence

	// a read with no event in its access cycle leaves every bit clear
	status_clear_a: assert property ((rdStatusSeq ##0 (evtRaw == 16'h0000)) |=>
		evtStatus == 16'h0000)
		else $error("status not cleared by read");

	status_set_wins_a: assert property ((rdStatusDone && evtRaw != 16'h0000) |=> evtStatus == $past(evtRaw))
		else $error("event lost against read clear");

	// status is read-only: a write neither sets nor clears it
	status_no_write_a: assert property ((accessPhase && apbReq.pwrite && hitStatus
		&& evtRaw == 16'h0000) |=> $stable(evtStatus))
		else $error("write changed status");

	// ----------------------------------------
	// mask storage
	// ----------------------------------------
	mask_ab_strobe_a: assert property ((accessPhase && apbReq.pwrite && hitAb
		&& !apbReq.pstrb[0]) |=> $stable(eventMaskCfgAb))
		else $error("a/b mask written without lane 0");

	mask_cd_strobe_a: assert property ((accessPhase && apbReq.pwrite && hitCd
		&& !apbReq.pstrb[0]) |=> $stable(eventMaskCfgCd))
		else $error("c/d mask written without lane 0");

	mask_ab_hold_a: assert property (!wrAb |=> $stable(eventMaskCfgAb))
		else $error("a/b mask changed without a write");

	mask_cd_hold_a: assert property (!wrCd |=> $stable(eventMaskCfgCd))
		else $error("c/d mask changed without a write");

	// ----------------------------------------
	// interrupt line
	// ----------------------------------------
	irq_pending_a: assert property ((|(evtStatus & ~maskAll)) |-> irq)
		else $error("pending unmasked status left interrupt low");

	irq_clear_read_a: assert property ((rdStatusDone && evtRaw == 16'h0000) |=> !irq)
		else $error("interrupt stayed high after status read");

	irq_idle_a: assert property ((next_evtStatus == 16'h0000) |=> !irq)
		else $error("interrupt high with no status");

	// masking everything silences the line on the write edge itself
	irq_all_masked_a: assert property ((wrAb && apbReq.pwdata[7:0] == 8'hff
		&& next_eventMaskCfgCd == 8'hff) |=> !irq)
		else $error("interrupt high with all masks set");

	// ----------------------------------------
	// per event gating, one mask bit for each status bit
	// ----------------------------------------
	generate
		for (gi = 0; gi < NUM_EVT; gi++) begin : gGateChk
			evt_gate_on_a: assert property ((evtRaw[gi] && !next_maskAll[gi]) |=> irq)
				else $error("unmasked event left interrupt low");
			evt_gate_off_a: assert property ((evtStatus[gi] && maskAll[gi]
				&& (evtStatus & ~maskAll) == 16'h0000) |-> !irq)
				else $error("masked status bit raised interrupt");
			// a pending masked event fires as soon as its mask is cleared
			unmask_pending_a: assert property ((evtStatus[gi] && !rdStatusDone
				&& !next_maskAll[gi]) |=> irq)
				else $error("unmasking a pending event left interrupt low");
			status_set_bit_a: assert property (evtRaw[gi] |=> evtStatus[gi])
				else $error("event did not set its status bit");
			status_hold_bit_a: assert property ((evtStatus[gi] && !rdStatusDone) |=> evtStatus[gi])
				else $error("status bit dropped without a read");
		end
	endgenerate

endmodule

// [verif/remask_host.sv]
// host model: counts interrupt assertions seen on the line
`timescale 1ns/1ps
module remask_host (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// interrupt line and its count
	input wire logic irq,
	output logic [7:0] irqCount
);
	logic irqPrev;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irqPrev <= 1'h0;
			irqCount <= 8'h00;
		end else begin
			irqPrev <= irq;
			irqCount <= irqCount + {7'h00, irq & ~irqPrev};
		end
	end
endmodule

// [verif/remask_test.sv]
// self-checking bench for the receiver event mask block
`timescale 1ns/1ps
module remask_test
	import remask_pkg::*;
;
	logic clk;
	logic rst_n;
	logic [15:0] evts;
	remask_apb_req_t req;
	remask_apb_rsp_t rsp;
	logic irq;
	logic [7:0] irqCount;
	logic [31:0] q;
	logic e;
	logic [13:0] ma;
	int n_mismatch;
	int compares;

	remask_top remask_top_inst (.clk(clk), .rst_n(rst_n), .apbReq(req), .apbRsp(rsp),
		.evtCfgA(remask_evt_t'(evts[3:0])), .evtCfgB(remask_evt_t'(evts[7:4])),
		.evtCfgC(remask_evt_t'(evts[11:8])), .evtCfgD(remask_evt_t'(evts[15:12])),
		.irq(irq));
	remask_host remask_host_inst (.clk(clk), .rst_n(rst_n), .irq(irq), .irqCount(irqCount));

	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic final_report;
		$display("compares=%0d mismatches=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// idle cycle at the end so the next request never re-drives req in one step
	task automatic xfer(input logic [13:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		req <= '{paddr: a, psel: 1'h1, penable: 1'h0, pwrite: w, pwdata: d, pstrb: 4'hf};
		@(posedge clk);
		req.penable <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'h1 && n < 50);
		if (n >= 50) begin
			n_mismatch++;
			final_report();
		end
		q = rsp.prdata;
		e = rsp.pslverr;
		req <= '0;
		@(posedge clk);
	endtask

	task automatic pulse(input int i);
		evts <= 16'h0001 << i;
		@(posedge clk);
		evts <= 16'h0000;
		repeat (3) @(posedge clk);
	endtask

	initial begin
		rst_n = 1'h0;
		evts = 16'h0000;
		req = '0;
		n_mismatch = 0;
		compares = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		xfer(ADDR_MASK_AB, 1'h0, 32'h0);
		chk(q, 32'h0);
		xfer(ADDR_MASK_CD, 1'h0, 32'h0);
		chk(q, 32'h0);
		for (int i = 0; i < 16; i++) begin
			pulse(i);
			chk({31'h0, irq}, 32'h1);
			xfer(ADDR_EVT_STATUS, 1'h0, 32'h0);
			chk(q, 32'h1 << i);
			repeat (2) @(posedge clk);
			chk({31'h0, irq}, 32'h0);
			ma = (i < 8) ? ADDR_MASK_AB : ADDR_MASK_CD;
			xfer(ma, 1'h1, 32'h1 << (i % 8));
			pulse(i);
			chk({31'h0, irq}, 32'h0);
			xfer(ADDR_EVT_STATUS, 1'h0, 32'h0);
			xfer(ma, 1'h1, 32'h0);
		end
		xfer(ADDR_MASK_AB, 1'h1, 32'h5a);
		xfer(ADDR_MASK_CD, 1'h1, 32'ha5);
		xfer(ADDR_MASK_AB, 1'h0, 32'h0);
		chk(q, 32'h5a);
		xfer(ADDR_MASK_CD, 1'h0, 32'h0);
		chk(q, 32'ha5);
		evts <= 16'h0100;
		xfer(ADDR_EVT_RAW, 1'h0, 32'h0);
		chk(q, 32'h100);
		evts <= 16'h0000;
		xfer(ADDR_EVT_STATUS, 1'h1, 32'hffff);
		xfer(ADDR_EVT_STATUS, 1'h0, 32'h0);
		chk(q, 32'h100);
		chk({31'h0, irq}, 32'h0);
		xfer(ADDR_EVT_STATUS, 1'h0, 32'h0);
		chk(q, 32'h0);
		xfer(14'h3ffc, 1'h0, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk({24'h0, irqCount}, 32'h10);
		final_report();
	end
endmodule
